/* File: logic/ivp_resolver.sv */
// Interrupt vector selection, priority resolution and fetch address forming.
//
// Contract
// - Higher priority level always served first.
// - Same level: smallest vector number wins.
// - Fetch address is base plus vector offset.
// - Chip reset slot 0, watchdog slot 1.
// - Vectors 2 to 5 fixed at level 3.
// - Debug unit vectors 6-10 take levels 1-3.
// - Detector 15, PLL 16 levels 1-3; 14 reserved.
// - Entries two words; offset 2N; 19-bit entries.
// - Reset base makes slots overlay reset addresses.
`include "ivp_consts.svh"
// Pending sources are ranked by level first, then by number. The winner and
// its table address appear one clock after the requests that chose it.
// Requests come from logic on this clock, so they are used with no
// synchronisers; a source that pulses for less than a cycle may be missed.
module ivp_resolver
  import ivp_pkg::*;
#(
  parameter int NUM_VEC = `IVP_NUM_VEC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [NUM_VEC-1:0] irq_req,
  input wire logic [2*NUM_VEC-1:0] irq_level,
  input wire logic [`IVP_ADDR_W-1:0] vector_base_address,
  input wire logic vba_load,
  output logic irq_valid,
  output logic [`IVP_VEC_W-1:0] irq_vector,
  output logic [1:0] irq_prio,
  output logic [`IVP_ADDR_W-1:0] fetch_addr,
  output logic [`IVP_ENTRY_W-1:0] entry_addr,
  output logic [`IVP_ADDR_W-1:0] vba_r
);

  // ----------------------------------------------------------------
  // Effective levels
  // ----------------------------------------------------------------

  // True for the slots that never carry a request: both reset slots and the
  // reserved slot. The reset slots are entered through reset, never by arbitration.
  function automatic logic is_excluded(input int v);
    return (v == `IVP_VEC_RESET) || (v == `IVP_VEC_WDOG) || (v == `IVP_VEC_RSVD);
  endfunction : is_excluded

  // Returns the level a vector really runs at; zero means it cannot win.
  function automatic logic [1:0] eff_level(input int v, input logic [1:0] prog);
    logic [1:0] lv;
    lv = 2'h0;
    if (v >= `IVP_VEC_FIX_LO && v <= `IVP_VEC_FIX_HI) begin
      lv = `IVP_PRI_FIXED;
    end else if ((v >= `IVP_VEC_DBG_LO && v <= `IVP_VEC_DBG_HI) ||
                 v == `IVP_VEC_LVD || v == `IVP_VEC_PLL) begin
      lv = prog;
    end else if (v == `IVP_VEC_SW2) begin
      lv = 2'h2;
    end else if (v == `IVP_VEC_SW1) begin
      lv = 2'h1;
    end
    return lv;
  endfunction : eff_level

  // Effective level and contention flag of every vector.
  logic [1:0] lvl [NUM_VEC];
  logic [NUM_VEC-1:0] live;

  // Per vector: reset slots, reserved slot and idle sources are excluded.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_VEC; gi++) begin : g_lvl
      assign lvl[gi] = eff_level(gi, irq_level[2*gi +: 2]);
      // A source contends only with a request and a nonzero level.
      assign live[gi] = irq_req[gi] && (lvl[gi] != 2'h0) &&
                        !is_excluded(gi);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------

  logic win_valid;
  logic [`IVP_VEC_W-1:0] win_vec;
  logic [1:0] win_lvl;

  // Scan downward so a lower vector at an equal level overrides.
  always_comb begin
    win_valid = 1'b0;
    win_vec = '0;
    win_lvl = 2'h0;
    for (int v = NUM_VEC - 1; v >= 0; v--) begin
      if (live[v] && (!win_valid || lvl[v] >= win_lvl)) begin
        win_valid = 1'b1;
        win_vec = `IVP_VEC_W'(v);
        win_lvl = lvl[v];
      end
    end
  end

  // Cross-check of the scan, written without its scan order: a live source
  // beats the winner at a higher level, or at the same level with a smaller
  // number. No such source may exist whenever a winner is named.
  logic [NUM_VEC-1:0] beats_win;
  genvar gb;
  generate
    for (gb = 0; gb < NUM_VEC; gb++) begin : g_beat
      assign beats_win[gb] = live[gb] && ((lvl[gb] > win_lvl) ||
                             ((lvl[gb] == win_lvl) && (gb < win_vec)));
    end
  endgenerate

  a_none_better: assert property (@(posedge sys_clk) disable iff (sys_rst)
    win_valid |-> beats_win == '0)
    else $error("a better pending source was passed over");

  // A winner is named exactly when some source contends.
  a_valid_any: assert property (@(posedge sys_clk) disable iff (sys_rst)
    win_valid == (live != '0))
    else $error("winner flag disagrees with pending sources");

  // Programmable sources win only at their programmed, nonzero level.
  a_prog_level: assert property (@(posedge sys_clk) disable iff (sys_rst)
    win_valid &&
    (win_vec inside {[`IVP_VEC_DBG_LO:`IVP_VEC_DBG_HI], `IVP_VEC_LVD, `IVP_VEC_PLL})
    |-> win_lvl == irq_level[{win_vec, 1'h0} +: 2] && win_lvl != 2'h0)
    else $error("programmable source won at a wrong level");

  // ----------------------------------------------------------------
  // Base register and outputs
  // ----------------------------------------------------------------

  // Base register. Its reset value puts slots 0 and 1 on the boot and
  // watchdog restart addresses; loading a new base moves the whole table,
  // and the new base applies from the next edge on.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      vba_r <= `IVP_VBA_RST;
    end else if (vba_load) begin
      vba_r <= vector_base_address;
    end
  end

  logic [`IVP_ADDR_W-1:0] addr_nxt;
  // Each entry takes two words, so the offset is twice the vector number.
  assign addr_nxt = vba_r + {{(`IVP_ADDR_W-`IVP_VEC_W-1){1'b0}}, win_vec, 1'b0};

  // Registered winner: flag, vector and level always move together.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_valid <= 1'b0;
      irq_vector <= '0;
      irq_prio <= 2'h0;
    end else begin
      irq_valid <= win_valid;
      irq_vector <= win_vec;
      irq_prio <= win_lvl;
    end
  end

  // Registered fetch address. It uses the base held before this edge, so a
  // base load in the same cycle only applies to the next winner.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fetch_addr <= `IVP_VBA_RST;
      entry_addr <= '0;
    end else begin
      fetch_addr <= addr_nxt;
      entry_addr <= addr_nxt[`IVP_ENTRY_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  // The address uses the base from before the edge that named the winner.
  a_addr_form: assert property (@(posedge sys_clk) disable iff (sys_rst)
    irq_valid |-> fetch_addr == $past(vba_r) + {irq_vector, 1'h0})
    else $error("fetch address not base plus twice vector");

  // Reset slots and the reserved slot are never offered.
  a_no_reserved: assert property (@(posedge sys_clk) disable iff (sys_rst)
    irq_valid |-> irq_vector != `IVP_VEC_RSVD && irq_vector > `IVP_VEC_WDOG)
    else $error("reserved or reset vector presented");

  // Core exception vectors always run at the top level.
  a_fixed_level: assert property (@(posedge sys_clk) disable iff (sys_rst)
    irq_valid && irq_vector >= `IVP_VEC_FIX_LO && irq_vector <= `IVP_VEC_FIX_HI
    |-> irq_prio == 2'h3)
    else $error("fixed vector not at level 3");

  // Vector 2 is the lowest number at the top level, so it wins whenever asked.
  a_fixed_beats: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $past(irq_req[2]) && !$past(sys_rst) |-> irq_valid && irq_vector == 5'h02)
    else $error("vector 2 pending but not chosen");

  // With nothing pending, nothing is offered one cycle later.
  a_idle_none: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $past(irq_req) == '0 && !$past(sys_rst) |-> !irq_valid)
    else $error("valid without any request");

  // A level 3 request from the clock source forces a level 3 winner.
  a_level_max: assert property (@(posedge sys_clk) disable iff (sys_rst)
    irq_valid && $past(irq_req[`IVP_VEC_PLL]) && $past(irq_level[33:32]) == 2'h3
    |-> irq_prio == 2'h3)
    else $error("level 3 request lost to lower level");

  // The entry address is the table address cut to the reach of one entry.
  a_entry_range: assert property (@(posedge sys_clk) disable iff (sys_rst)
    irq_valid |-> entry_addr == `IVP_ENTRY_W'($past(vba_r) + {irq_vector, 1'h0}))
    else $error("entry address not base plus twice vector");

  // Reset returns the base to its reset value whatever else is asked.
  a_base_reset: assert property (@(posedge sys_clk)
    $past(sys_rst) |-> vba_r == `IVP_VBA_RST)
    else $error("base not at reset value after reset");

  // Straight after reset nothing is offered and the address sits on the base.
  a_reset_quiet: assert property (@(posedge sys_clk)
    $past(sys_rst) |-> !irq_valid && fetch_addr == `IVP_VBA_RST)
    else $error("winner or address not cleared by reset");

endmodule : ivp_resolver

/* File: include/ivp_consts.svh */
// Constants for the interrupt vector priority resolver.
`ifndef IVP_CONSTS_SVH
`define IVP_CONSTS_SVH
`define IVP_NUM_VEC 17
`define IVP_VEC_W 5
`define IVP_ADDR_W 21
`define IVP_ENTRY_W 19
`define IVP_VBA_RST 21'h000000
`define IVP_VEC_RESET 5'h00
`define IVP_VEC_WDOG 5'h01
`define IVP_VEC_FIX_LO 5'h02
`define IVP_VEC_FIX_HI 5'h05
`define IVP_VEC_DBG_LO 5'h06
`define IVP_VEC_DBG_HI 5'h0a
`define IVP_VEC_SW2 5'h0b
`define IVP_VEC_SW1 5'h0c
`define IVP_VEC_SW0 5'h0d
`define IVP_VEC_RSVD 5'h0e
`define IVP_VEC_LVD 5'h0f
`define IVP_VEC_PLL 5'h10
`define IVP_PRI_FIXED 2'h3
`endif

/* File: include/ivp_pkg.sv */
// Types for the interrupt vector priority resolver.
package ivp_pkg;
  typedef logic [1:0] ivp_level_t;
  typedef logic [4:0] ivp_vec_t;
endpackage : ivp_pkg

/* File: bench/ivp_core_model.sv */
// Core-side partner model that takes vector fetch addresses.
module ivp_core_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic irq_valid,
  input wire logic [20:0] fetch_addr,
  output logic [20:0] last_fetch
);
  timeunit 1ns;
  timeprecision 1ps;
  // The core latches the address whenever a vector is offered; reset clears it.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) last_fetch <= '0;
    else if (irq_valid) last_fetch <= fetch_addr;
  end
endmodule : ivp_core_model

/* File: bench/interrupt_vector_priority_bench.sv */
// Self-checking bench for the vector priority resolver.
`include "ivp_consts.svh"
module interrupt_vector_priority_bench;
  import ivp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, sys_rst = 1, vba_load = 0, irq_valid, e_valid;
  logic [16:0] irq_req = '0;
  logic [33:0] irq_level = '0;
  logic [20:0] vba_in = '0, base = '0, e_fetch, fetch_addr, vba_r, last_fetch, e_last = '0;
  logic [18:0] entry_addr;
  ivp_vec_t irq_vector, e_vec;
  ivp_level_t irq_prio, e_prio;
  int fails = 0, comparisons = 0, seed = 20;
  logic [16:0] corner [4] = '{17'h04003, 17'h02000, 17'h1ffff, 17'h18040};
  ivp_resolver ivp_resolver_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .irq_req(irq_req),
    .irq_level(irq_level), .vector_base_address(vba_in), .vba_load(vba_load),
    .irq_valid(irq_valid), .irq_vector(irq_vector), .irq_prio(irq_prio),
    .fetch_addr(fetch_addr), .entry_addr(entry_addr), .vba_r(vba_r));
  ivp_core_model ivp_core_model_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .irq_valid(irq_valid), .fetch_addr(fetch_addr), .last_fetch(last_fetch));
  initial forever #4 sys_clk = ~sys_clk;
  task check(input logic [20:0] seen, input logic [20:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Level that each vector contends at; zero means it never wins.
  function automatic ivp_level_t lvl_of(int v);
    case (v)
      2, 3, 4, 5: return 2'h3;
      11: return 2'h2;
      12: return 2'h1;
      6, 7, 8, 9, 10, 15, 16: return irq_level[2*v+:2];
      default: return 2'h0;
    endcase
  endfunction : lvl_of
  // Highest level first, then the lowest number pending at that level.
  task predict;
    e_valid = 0;
    e_prio = 0;
    e_vec = 0;
    for (int l = 3; l >= 1; l--) begin
      for (int v = 0; v <= 16; v++) begin
        if (!e_valid && irq_req[v] && lvl_of(v) == 2'(l)) begin
          e_valid = 1;
          e_prio = 2'(l);
          e_vec = 5'(v);
        end
      end
    end
    e_fetch = base + {15'h0000, e_vec, 1'b0};
  endtask : predict
  task final_report;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  initial begin
    #5000;
    fails++;
    final_report();
  end
  initial begin
    repeat (20) @(negedge sys_clk);
    sys_rst = 0;
    @(negedge sys_clk);
    check(vba_r, 21'h000000);
    for (int i = 0; i < 400; i++) begin
      // Mid-run reset: one cycle clears the outputs, the base and the core's copy.
      if (i == 200) begin
        sys_rst = 1;
        @(negedge sys_clk);
        check(21'(irq_valid), 21'h0);
        check(vba_r, `IVP_VBA_RST);
        sys_rst = 0;
        base = `IVP_VBA_RST;
        e_last = '0;
      end
      irq_req = (i < 4) ? corner[i] : 17'($random(seed));
      irq_level[31:0] = $random(seed);
      irq_level[33:32] = 2'($random(seed));
      vba_in = 21'($random(seed));
      vba_load = (2'($random(seed)) == 2'h0);
      predict();
      if (vba_load) base = vba_in;
      @(negedge sys_clk);
      check(21'(irq_valid), 21'(e_valid));
      check(vba_r, base);
      check(last_fetch, e_last);
      if (e_valid) begin
        check(21'(irq_vector), 21'(e_vec));
        check(21'(irq_prio), 21'(e_prio));
        check(fetch_addr, e_fetch);
        check(21'(entry_addr), 21'(e_fetch[18:0]));
        e_last = e_fetch;
      end
    end
    $display("random priority test done");
    final_report();
  end
endmodule : interrupt_vector_priority_bench
